// File: dpll_reference_profile_regs.sv
// fourth-reference profile banks for three digital loops, with selection
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module dpll_reference_profile_regs #(
  parameter int NL = dpll_ref_pkg::NUM_LOOPS,  // loops with a bank
  parameter int NR = dpll_ref_pkg::NUM_REFS    // references per loop
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // register port
  input  wire logic [11:0]              reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // reference qualification pins, one per reference input
  input  wire logic [NR-1:0]            ref_usable_pin,
  // settings of the first three references, per loop
  input  wire logic [NL-1:0][2:0][1:0]  other_ref_priority,
  input  wire logic [NL-1:0][2:0]       other_ref_enable,
  // decoded fields of the fourth reference, per loop
  output logic      [NL-1:0][1:0]       fourth_ref_priority,
  output logic      [NL-1:0]            fourth_ref_enable,
  output logic      [NL-1:0][16:0]      loop_bw_scale,
  output logic      [NL-1:0]            high_margin_filter,
  output logic      [NL-1:0][17:0]      integer_feedback_count,
  output logic      [NL-1:0][23:0]      fractional_numerator,
  output logic      [NL-1:0][23:0]      fractional_modulus,
  // chosen reference per loop
  output logic      [NL-1:0][1:0]       sel_ref,
  output logic      [NL-1:0]            sel_valid
);

  // ------------------------------------------------------------------
  // bank storage
  // ------------------------------------------------------------------

  logic [NL-1:0][12:0][7:0] bank_bytes;  // raw bytes of each bank
  logic [NL-1:0]            bank_hit;    // read address lands in bank
  logic [NL-1:0][7:0]       bank_rd;     // byte read from each bank

  // one bank per loop, each placed one stride above the last
  genvar g;
  generate
    for (g = 0; g < NL; g++)
    begin : gen_bank
      reference_profile_bank #(
        .BASE (12'(dpll_ref_pkg::BANK_BASE
                   + 12'(g) * dpll_ref_pkg::LOOP_STRIDE))
      ) u_bank (
        .clock     (clock),
        .rst       (rst),
        .addr      (reg_addr),
        .wdata     (reg_wdata),
        .wr_stb    (reg_wr),
        .rd_hit    (bank_hit[g]),
        .rd_byte   (bank_rd[g]),
        .bytes_out (bank_bytes[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // field decode, straight from the bank flip-flops
  // ------------------------------------------------------------------

  generate
    for (g = 0; g < NL; g++)
    begin : gen_fields
      // control byte: enable in bit 0
      assign fourth_ref_enable[g] =
        bank_bytes[g][dpll_ref_pkg::IDX_CTRL][dpll_ref_pkg::ENABLE_BIT];
      // control byte: priority level in bits 2:1
      assign fourth_ref_priority[g] =
        bank_bytes[g][dpll_ref_pkg::IDX_CTRL][dpll_ref_pkg::PRIO_LSB +: 2];
      // bandwidth in 0.1 Hz steps, bit 16 in the third byte
      assign loop_bw_scale[g] = {
        bank_bytes[g][dpll_ref_pkg::IDX_BW_HI][dpll_ref_pkg::BW16_BIT],
        bank_bytes[g][dpll_ref_pkg::IDX_BW_MID],
        bank_bytes[g][dpll_ref_pkg::IDX_BW_LO]};
      // filter pick: 0 normal margin, 1 high margin
      assign high_margin_filter[g] =
        bank_bytes[g][dpll_ref_pkg::IDX_BW_HI][dpll_ref_pkg::FILTER_BIT];
      // divider held as ratio minus one, top two bits in the third byte
      assign integer_feedback_count[g] = {
        bank_bytes[g][dpll_ref_pkg::IDX_DIV_HI][1:0],
        bank_bytes[g][dpll_ref_pkg::IDX_DIV_MID],
        bank_bytes[g][dpll_ref_pkg::IDX_DIV_LO]};
      // numerator, low byte at the lowest address
      assign fractional_numerator[g] = {
        bank_bytes[g][dpll_ref_pkg::IDX_NUM_HI],
        bank_bytes[g][dpll_ref_pkg::IDX_NUM_MID],
        bank_bytes[g][dpll_ref_pkg::IDX_NUM_LO]};
      // modulus, low byte at the lowest address
      assign fractional_modulus[g] = {
        bank_bytes[g][dpll_ref_pkg::IDX_MOD_HI],
        bank_bytes[g][dpll_ref_pkg::IDX_MOD_MID],
        bank_bytes[g][dpll_ref_pkg::IDX_MOD_LO]};
    end
  endgenerate

  // ------------------------------------------------------------------
  // read data: one cycle after the strobe, zero otherwise
  // ------------------------------------------------------------------

  logic [7:0] rdata_q;  // registered read data
  logic [7:0] rdata_d;  // next read data

  // merge bank answers; banks never overlap so at most one hits
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      for (int i = 0; i < NL; i++)
      begin
        if (bank_hit[i])
          rdata_d = rdata_d | bank_rd[i];
      end
    end
  end

  // read data register; unmapped addresses answer zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------------
  // usable pins: three-stage synchroniser with agreement filter
  // ------------------------------------------------------------------

  logic [NR-1:0] sync1_q;   // first stage, read only by the second
  logic [NR-1:0] sync2_q;   // second stage
  logic [NR-1:0] sync3_q;   // third stage
  logic [NR-1:0] usable_q;  // accepted level
  logic [NR-1:0] usable_d;  // next accepted level

  // a change counts once stages two and three agree
  always_comb
  begin
    usable_d = usable_q;
    for (int i = 0; i < NR; i++)
    begin
      if (sync2_q[i] == sync3_q[i])
        usable_d[i] = sync3_q[i];
    end
  end

  // synchroniser chain and accepted level
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_q  <= dpll_ref_pkg::RST_USABLE;
      sync2_q  <= dpll_ref_pkg::RST_USABLE;
      sync3_q  <= dpll_ref_pkg::RST_USABLE;
      usable_q <= dpll_ref_pkg::RST_USABLE;
    end
    else
    begin
      sync1_q  <= ref_usable_pin;
      sync2_q  <= sync1_q;
      sync3_q  <= sync2_q;
      usable_q <= usable_d;
    end
  end

  // ------------------------------------------------------------------
  // reference selection per loop
  // ------------------------------------------------------------------

  // picks the enabled, usable input with the lowest level;
  // ties go to the lowest input number; returns {valid, index}
  function automatic logic [2:0] pick(
    input logic [3:0]      en,
    input logic [3:0][1:0] lvl,
    input logic [3:0]      ok
  );
    logic       found;
    logic [1:0] best;
    logic [1:0] best_lvl;
    found    = 1'b0;
    best     = 2'd0;
    best_lvl = 2'd3;
    for (int i = 0; i < 4; i++)
    begin
      if (en[i] && ok[i] && (!found || lvl[i] < best_lvl))
      begin
        found    = 1'b1;
        best     = 2'(i);
        best_lvl = lvl[i];
      end
    end
    pick = {found, best};
  endfunction

  logic [NL-1:0][1:0] sel_ref_q;    // chosen input per loop
  logic [NL-1:0][1:0] sel_ref_d;    // next chosen input
  logic [NL-1:0]      sel_valid_q;  // an enabled, usable input exists
  logic [NL-1:0]      sel_valid_d;  // next valid flag

  // evaluate every loop from its four reference settings
  always_comb
  begin
    logic [2:0] res;
    res         = 3'd0;
    sel_ref_d   = sel_ref_q;
    sel_valid_d = sel_valid_q;
    for (int l = 0; l < NL; l++)
    begin
      res = pick({fourth_ref_enable[l], other_ref_enable[l]},
                 {fourth_ref_priority[l], other_ref_priority[l]},
                 usable_q);
      sel_valid_d[l] = res[2];
      sel_ref_d[l]   = res[1:0];
    end
  end

  // selection registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sel_ref_q   <= '0;
      sel_valid_q <= '0;
    end
    else
    begin
      sel_ref_q   <= sel_ref_d;
      sel_valid_q <= sel_valid_d;
    end
  end

  assign sel_ref   = sel_ref_q;
  assign sel_valid = sel_valid_q;

endmodule

// File: dpll_ref_pkg.sv
// constants for the per-loop fourth-reference profile register bank
// Overview of operation
// - two-bit priority in bits 2:1, 0 highest
// - bit 0 enables locking to this input
// - 17-bit bandwidth from three bytes, 0.1 Hz
// - bit 1 of third byte picks filter
// - 18-bit divider minus one over three bytes
// - 24-bit numerator, least significant byte first
// - 24-bit modulus, least significant byte first
// - second loop copy sits 0x0100 higher
// - third loop copy sits 0x0200 higher
package dpll_ref_pkg;

  localparam int ADDR_W    = 12;  // register address width
  localparam int DATA_W    = 8;   // register data width
  localparam int NUM_BYTES = 13;  // bytes in one bank
  localparam int NUM_LOOPS = 3;   // digital loops carrying a bank
  localparam int NUM_REFS  = 4;   // reference inputs per loop

  // byte offsets of the first loop's bank
  localparam logic [11:0] OFS_REF_PRIORITY_ENABLE = 12'h467;
  localparam logic [11:0] OFS_LOOP_BW_SCALE_LOW   = 12'h468;
  localparam logic [11:0] OFS_LOOP_BW_SCALE_MID   = 12'h469;
  localparam logic [11:0] OFS_LOOP_BW_SCALE_HIGH_FILTER_SEL = 12'h46a;
  localparam logic [11:0] OFS_INT_DIVIDER_LOW     = 12'h46b;
  localparam logic [11:0] OFS_INT_DIVIDER_MID     = 12'h46c;
  localparam logic [11:0] OFS_INT_DIVIDER_HIGH    = 12'h46d;
  localparam logic [11:0] OFS_FRAC_NUMERATOR_LOW  = 12'h46e;
  localparam logic [11:0] OFS_FRAC_NUMERATOR_MID  = 12'h46f;
  localparam logic [11:0] OFS_FRAC_NUMERATOR_HIGH = 12'h470;
  localparam logic [11:0] OFS_FRAC_MODULUS_LOW    = 12'h471;
  localparam logic [11:0] OFS_FRAC_MODULUS_MID    = 12'h472;
  localparam logic [11:0] OFS_FRAC_MODULUS_HIGH   = 12'h473;

  localparam logic [11:0] BANK_BASE   = OFS_REF_PRIORITY_ENABLE;
  localparam logic [11:0] LOOP_STRIDE = 12'h100;

  // byte index of each register inside a bank
  localparam int IDX_CTRL    = 0;
  localparam int IDX_BW_LO   = 1;
  localparam int IDX_BW_MID  = 2;
  localparam int IDX_BW_HI   = 3;
  localparam int IDX_DIV_LO  = 4;
  localparam int IDX_DIV_MID = 5;
  localparam int IDX_DIV_HI  = 6;
  localparam int IDX_NUM_LO  = 7;
  localparam int IDX_NUM_MID = 8;
  localparam int IDX_NUM_HI  = 9;
  localparam int IDX_MOD_LO  = 10;
  localparam int IDX_MOD_MID = 11;
  localparam int IDX_MOD_HI  = 12;

  // field positions
  localparam int ENABLE_BIT = 0;  // control byte enable
  localparam int PRIO_LSB   = 1;  // control byte priority low bit
  localparam int BW16_BIT   = 0;  // third bandwidth byte, bit 16
  localparam int FILTER_BIT = 1;  // third bandwidth byte, filter pick

  // writable bits per byte, index 12 down to 0; reserved bits stay 0
  localparam logic [12:0][7:0] BYTE_MASK = {
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h03, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h07};

  localparam logic [7:0] RST_BYTE  = 8'h00;  // every byte resets to zero
  localparam logic [3:0] RST_USABLE = 4'h0;  // no input usable at reset

endpackage

// File: reference_profile_bank.sv
// one thirteen-byte profile bank with its address decode
`timescale 1ns/1ps
module reference_profile_bank #(
  parameter logic [11:0] BASE = dpll_ref_pkg::BANK_BASE
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [11:0]           addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr_stb,
  output logic                       rd_hit,
  output logic      [7:0]            rd_byte,
  output logic      [12:0][7:0]      bytes_out
);

  logic [12:0][7:0] bytes_q;  // stored bytes
  logic [12:0][7:0] bytes_d;  // next bytes
  logic [4:0]       dec;      // hit flag and byte index

  // maps an address to {hit, index}; used by both read and write paths
  function automatic logic [4:0] decode(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - BASE;
    if (a >= BASE && rel < 12'(dpll_ref_pkg::NUM_BYTES))
      decode = {1'b1, rel[3:0]};
    else
      decode = 5'h00;
  endfunction

  assign dec = decode(addr);

  // write path: only writable bits are kept, reserved bits stay zero
  always_comb
  begin
    bytes_d = bytes_q;
    if (wr_stb && dec[4])
    begin
      bytes_d[dec[3:0]] = wdata & dpll_ref_pkg::BYTE_MASK[dec[3:0]];
    end
  end

  // state register, all bytes clear at reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bytes_q <= {13{dpll_ref_pkg::RST_BYTE}};
    else
      bytes_q <= bytes_d;
  end

  // read path, combinational; the top registers it
  always_comb
  begin
    rd_hit  = dec[4];
    rd_byte = dec[4] ? bytes_q[dec[3:0]] : 8'h00;
  end

  assign bytes_out = bytes_q;

endmodule

// File: dpll_reference_profile_regs_properties.sv
// concurrent checks on the profile banks' register port and fields
`timescale 1ns/1ps
module dpll_reference_profile_regs_properties #(
  parameter int NL = 3,  // loops
  parameter int NR = 4   // references
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic [11:0]         reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic [NL-1:0][1:0]  fourth_ref_priority,
  input wire logic [NL-1:0]       fourth_ref_enable,
  input wire logic [NL-1:0][16:0] loop_bw_scale,
  input wire logic [NL-1:0]       high_margin_filter,
  input wire logic [NL-1:0][17:0] integer_feedback_count,
  input wire logic [NL-1:0][23:0] fractional_numerator,
  input wire logic [NL-1:0][23:0] fractional_modulus,
  input wire logic [NL-1:0][1:0]  sel_ref,
  input wire logic [NL-1:0]       sel_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // read data is zero except right after a read
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  // control byte drives enable and priority
  ctrl_write_a: assert property (reg_wr && reg_addr == 12'h467 |=>
    {fourth_ref_priority[0], fourth_ref_enable[0]} == $past(reg_wdata[2:0]))
    else $error("control byte not decoded");
  // third bandwidth byte: bit 16 and filter pick
  bw_top_a: assert property (reg_wr && reg_addr == 12'h46a |=>
    {high_margin_filter[0], loop_bw_scale[0][16]} == $past(reg_wdata[1:0]))
    else $error("bandwidth top byte wrong");
  // divider top bits
  div_top_a: assert property (reg_wr && reg_addr == 12'h46d |=>
    integer_feedback_count[0][17:16] == $past(reg_wdata[1:0]))
    else $error("divider top bits wrong");
  // numerator high byte
  num_top_a: assert property (reg_wr && reg_addr == 12'h470 |=>
    fractional_numerator[0][23:16] == $past(reg_wdata))
    else $error("numerator high byte wrong");
  // modulus low byte
  mod_low_a: assert property (reg_wr && reg_addr == 12'h471 |=>
    fractional_modulus[0][7:0] == $past(reg_wdata))
    else $error("modulus low byte wrong");
  // second loop copy one page up
  loop1_ctrl_a: assert property (reg_wr && reg_addr == 12'h567 |=>
    {fourth_ref_priority[1], fourth_ref_enable[1]} == $past(reg_wdata[2:0]))
    else $error("second loop control wrong");
  // third loop copy two pages up
  loop2_mod_a: assert property (reg_wr && reg_addr == 12'h673 |=>
    fractional_modulus[2][23:16] == $past(reg_wdata))
    else $error("third loop modulus wrong");
  // reserved control bits read zero
  ctrl_rsvd_a: assert property (reg_rd && reg_addr == 12'h467 |=>
    reg_rdata[7:3] == 5'h00)
    else $error("reserved control bits set");
  // the first loop never chooses a disabled fourth input
  sel_enabled_a: assert property (sel_valid[0] && sel_ref[0] == 2'd3 |->
    $past(fourth_ref_enable[0]))
    else $error("disabled input chosen");
endmodule

bind dpll_reference_profile_regs dpll_reference_profile_regs_properties
  #(.NL(NL), .NR(NR)) u_props (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fourth_ref_priority(fourth_ref_priority),
  .fourth_ref_enable(fourth_ref_enable), .loop_bw_scale(loop_bw_scale),
  .high_margin_filter(high_margin_filter),
  .integer_feedback_count(integer_feedback_count),
  .fractional_numerator(fractional_numerator),
  .fractional_modulus(fractional_modulus), .sel_ref(sel_ref),
  .sel_valid(sel_valid));

// File: dpll_reference_profile_regs_tb.sv
// self-checking bench for the three profile banks and selection
`timescale 1ns/1ps
module dpll_reference_profile_regs_tb;
  typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic [11:0]          reg_addr = 12'h000;
  logic [7:0]           reg_wdata = 8'h00;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [7:0]           reg_rdata;
  logic [3:0]           ref_usable_pin = 4'h0;
  logic [2:0][2:0][1:0] other_ref_priority = '0;
  logic [2:0][2:0]      other_ref_enable = '0;
  logic [2:0][1:0]      fourth_ref_priority, sel_ref;
  logic [2:0]           fourth_ref_enable, high_margin_filter, sel_valid;
  logic [2:0][16:0]     loop_bw_scale;
  logic [2:0][17:0]     integer_feedback_count;
  logic [2:0][23:0]     fractional_numerator, fractional_modulus;
  int                   fail_count = 0;
  int                   n_compared = 0;
  int                   cyc = 0;
  logic [7:0]           rv;
  // write, read-back expectation; reserved bits masked, unmapped read 0
  row_s rows [17] = '{
    '{12'h467, 8'hff, 8'h07}, '{12'h468, 8'h34, 8'h34},
    '{12'h469, 8'h12, 8'h12}, '{12'h46a, 8'hff, 8'h03},
    '{12'h46b, 8'hcd, 8'hcd}, '{12'h46c, 8'hab, 8'hab},
    '{12'h46d, 8'hfe, 8'h02}, '{12'h46e, 8'h11, 8'h11},
    '{12'h46f, 8'h22, 8'h22}, '{12'h470, 8'h33, 8'h33},
    '{12'h471, 8'h44, 8'h44}, '{12'h472, 8'h55, 8'h55},
    '{12'h473, 8'h66, 8'h66}, '{12'h567, 8'h05, 8'h05},
    '{12'h673, 8'h9a, 8'h9a}, '{12'h474, 8'hff, 8'h00},
    '{12'h767, 8'hff, 8'h00}};

  dpll_reference_profile_regs u_dut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_usable_pin(ref_usable_pin),
    .other_ref_priority(other_ref_priority),
    .other_ref_enable(other_ref_enable),
    .fourth_ref_priority(fourth_ref_priority),
    .fourth_ref_enable(fourth_ref_enable), .loop_bw_scale(loop_bw_scale),
    .high_margin_filter(high_margin_filter),
    .integer_feedback_count(integer_feedback_count),
    .fractional_numerator(fractional_numerator),
    .fractional_modulus(fractional_modulus), .sel_ref(sel_ref),
    .sel_valid(sel_valid));

  // 25 ns period
  always #12.5 clock = ~clock;

  // compare one result, count and report
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(logic [11:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // every byte of all three banks resets to zero
    for (int l = 0; l < 3; l++)
      for (int i = 0; i < 13; i++)
      begin
        rd(12'(12'h467 + 256 * l + i), rv);
        chk("reset byte", 8'h00, rv);
      end
    // table of ordinary writes and read-backs
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a, rv);
      chk("read back", rows[k].e, rv);
    end
    // 7019.6 Hz: above 50 Hz, low enough for the detector rate in use
    chk("bandwidth", 17'h11234, loop_bw_scale[0]);
    // above 2 kHz, so the high margin filter is chosen
    chk("filter", 1'b1, high_margin_filter[0]);
    chk("divider", 18'h2abcd, integer_feedback_count[0]);
    chk("numerator", 24'h332211, fractional_numerator[0]);
    chk("modulus", 24'h665544, fractional_modulus[0]);
    chk("loop1 ctrl", 3'h5, {fourth_ref_priority[1], fourth_ref_enable[1]});
    chk("loop2 mod", 24'h9a0000, fractional_modulus[2]);
    // fourth input becomes usable: both enabled loops pick it
    @(posedge clock);
    ref_usable_pin <= 4'h8;
    repeat (8) @(posedge clock);
    #1 chk("sel valid", 3'h3, sel_valid);
    chk("sel loop0", 2'd3, sel_ref[0]);
    // equal level 3 on input 0: lowest index wins
    @(posedge clock);
    other_ref_priority[0][0] <= 2'd3;
    other_ref_enable[0][0] <= 1'b1;
    ref_usable_pin <= 4'h9;
    repeat (8) @(posedge clock);
    #1 chk("sel tie", 2'd0, sel_ref[0]);
    // fourth input raised to level 0 wins
    wr(12'h467, 8'h01);
    repeat (3) @(posedge clock);
    #1 chk("sel level", 2'd3, sel_ref[0]);
    // fourth disabled, input 0 unusable: nothing chosen
    wr(12'h467, 8'h00);
    ref_usable_pin <= 4'h8;
    repeat (8) @(posedge clock);
    #1 chk("sel none", 1'b0, sel_valid[0]);
    // reset in mid-run clears the copies too
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(12'h567, rv);
    chk("ctrl after reset", 8'h00, rv);
    chk("bw after reset", 17'h0, loop_bw_scale[0]);
    tally_and_finish();
  end
endmodule
